//--- common/ewc_pkg.sv
// Shared constants for the nonvolatile write control block.
// Assumes a single 100 MHz system clock and an AHB-Lite register bus.
package ewc_pkg;

    // Register byte offsets
    localparam logic [7:0] EWC_OFS_CTRL     = 8'h00;
    localparam logic [7:0] EWC_OFS_TMODE    = 8'h04;
    localparam logic [7:0] EWC_OFS_TCMP     = 8'h08;
    localparam logic [7:0] EWC_OFS_TCNT     = 8'h0C;
    localparam logic [7:0] EWC_OFS_ADDR     = 8'h10;
    localparam logic [7:0] EWC_OFS_DATA     = 8'h14;
    localparam logic [7:0] EWC_OFS_ISTAT    = 8'h18;
    localparam logic [7:0] EWC_OFS_IMASK    = 8'h1C;

    // Control register fields
    localparam int EWC_CTRL_WE     = 0;
    localparam int EWC_CTRL_BUSY   = 1;
    localparam int EWC_CTRL_RE     = 2;
    localparam int EWC_CTRL_ONE    = 3;
    localparam int EWC_CTRL_SEL_LO = 4;
    localparam int EWC_CTRL_PIN    = 7;

    // Count clock selections
    localparam logic [2:0] EWC_SEL_SYSDIV = 3'h4;
    localparam logic [2:0] EWC_SEL_TIMER  = 3'h6;
    localparam logic [2:0] EWC_SEL_RESET  = 3'h0;

    // Timer mode register fields
    localparam int EWC_TMODE_EN     = 7;
    localparam int EWC_TMODE_CLK_LO = 1;
    localparam logic [1:0] EWC_TCLK_DIV1 = 2'h0;
    localparam logic [1:0] EWC_TCLK_DIV2 = 2'h1;
    localparam logic [1:0] EWC_TCLK_DIV4 = 2'h2;

    // Interrupt status bits
    localparam int EWC_IRQ_DONE    = 0;
    localparam int EWC_IRQ_DISCARD = 1;
    localparam int EWC_IRQ_W       = 2;

    // Array layout
    localparam int EWC_ARRAY_BYTES = 256;
    localparam int EWC_AREA1_BYTES = 192;

    // Timing
    localparam int EWC_CLK_MHZ       = 100;
    localparam int EWC_ARM_TIME_US   = 1000;
    localparam int EWC_ARM_CYCLES    = EWC_ARM_TIME_US * EWC_CLK_MHZ;
    localparam int EWC_WRITE_PERIODS = 145;
    localparam int EWC_SYSDIV_RATIO  = 128;

    // AHB encodings
    localparam logic [2:0] EWC_HSIZE_WORD = 3'h2;

    // Access sequence states
    typedef enum logic [4:0] {
        EWC_STANDBY = 5'b00001,
        EWC_READ    = 5'b00010,
        EWC_ARM     = 5'b00100,
        EWC_WRITE   = 5'b01000,
        EWC_BLOCK   = 5'b10000
    } ewc_seq_t;

endpackage : ewc_pkg

//--- design/ewc_aux_timer.sv
// Auxiliary 8-bit timer with compare match and toggling output.
// Assumes the system clock; a prescaler gives the count rates.
`timescale 1ns/1ps
module ewc_aux_timer (
    input  wire logic       hclk,        // System clock
    input  wire logic       hresetn,     // Async reset, active low
    input  wire logic       enable,      // Count enable, zero clears
    input  wire logic [1:0] clk_sel,     // Count rate selection
    input  wire logic [7:0] compare,     // Match value
    output logic      [7:0] counter,     // Current count
    output logic            toggle_q,    // Toggle flip-flop output
    output logic            period_tick  // Pulse on toggle rising edge
);
    import ewc_pkg::*;

    logic [1:0] pre_reg;
    logic [7:0] cnt_reg;
    logic       tog_reg;
    logic       tick_reg;

    // Prescaler taps
    wire count_en = (clk_sel == EWC_TCLK_DIV1) ||
                    ((clk_sel == EWC_TCLK_DIV2) && pre_reg[0]) ||
                    ((clk_sel == EWC_TCLK_DIV4) && (pre_reg == 2'h3));
    wire match    = enable && count_en && (cnt_reg == compare);

    // Free running prescaler, cleared while stopped
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pre_reg <= 2'h0;
        end else begin
            pre_reg <= enable ? pre_reg + 2'h1 : 2'h0;
        end
    end

    // Counter clears on match; output flips at each match
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt_reg  <= 8'h00;
            tog_reg  <= 1'b0;
            tick_reg <= 1'b0;
        end else if (!enable) begin
            cnt_reg  <= 8'h00;
            tog_reg  <= 1'b0;
            tick_reg <= 1'b0;
        end else begin
            tick_reg <= match && !tog_reg;
            if (match) begin
                cnt_reg <= 8'h00;
                tog_reg <= !tog_reg;
            end else if (count_en) begin
                cnt_reg <= cnt_reg + 8'h01;
            end
        end
    end

    assign counter     = cnt_reg;
    assign toggle_q    = tog_reg;
    assign period_tick = tick_reg;

endmodule : ewc_aux_timer

//--- design/ewc_top.sv
// Write control for an on-chip byte array behind an AHB-Lite slave.
// Assumes single word transfers, one clock, asynchronous low reset.
//
// Function
// - Read enable, then write enable, then 1 ms wait; else never writable.
// - Count clock stopped at selection blocks the writable state for good.
// - Each write lasts 145 count periods; timer clock is toggle output.
// - Setting read enable makes the array readable.
// - Clearing read enable also clears write enable; no access then.
// - A write while busy is discarded.
// - Read enable zero puts the array into low-power standby.
// - Stop forces low power and keeps enables; halt changes nothing.
// - Protect pin low ignores upper 64-byte writes; lower 192 unaffected.
// - Busy one blocks reads and writes; zero allows them.
// - Enable pairs: 00 standby, 10 read, 11 read/write, 01 prohibited.
//
// Implementation choices: register access over AHB-Lite and the address map.
`timescale 1ns/1ps
module ewc_top #(
    parameter int ARM_CYCLES = ewc_pkg::EWC_ARM_CYCLES // Write arm wait
) (
    input  wire logic        hclk,        // System clock, 100 MHz
    input  wire logic        hresetn,     // Async reset, active low
    input  wire logic        hsel,        // Slave select
    input  wire logic [7:0]  haddr,       // Byte address
    input  wire logic [1:0]  htrans,      // Transfer type
    input  wire logic        hwrite,      // Write transfer
    input  wire logic [2:0]  hsize,       // Transfer size
    input  wire logic [31:0] hwdata,      // Write data
    input  wire logic        hready,      // Bus ready in
    output logic             hreadyout,   // Slave ready
    output logic             hresp,       // Always OKAY
    output logic      [31:0] hrdata,      // Read data
    input  wire logic        upper_area_write_protect_pin, // Low protects
    input  wire logic        stop_mode,   // Processor in stop
    output logic             array_standby,   // Array in low power
    output logic             write_busy_flag, // Cell write in progress
    output logic             irq              // Level interrupt
);
    import ewc_pkg::*;

    // Refuse an arm wait that the 20-bit counter cannot hold
    if (ARM_CYCLES < 1 || ARM_CYCLES > 2**20) begin : g_arm_check
        $error("ewc_top: ARM_CYCLES out of range");
    end

    // Bus state
    logic        dph_reg;
    logic        dwr_reg;
    logic [7:0]  daddr_reg;
    logic        hready_reg;
    logic [31:0] hrdata_reg;

    // Software visible state
    logic        re_reg;
    logic        we_reg;
    logic [2:0]  sel_reg;
    logic        clk_ok_reg;
    logic [7:0]  tmode_reg;
    logic [7:0]  tcmp_reg;
    logic [7:0]  aaddr_reg;
    logic [EWC_IRQ_W-1:0] istat_reg;
    logic [EWC_IRQ_W-1:0] imask_reg;
    logic        irq_reg;
    logic        stby_reg;

    // Sequence and write timing
    ewc_seq_t    seq_reg;
    ewc_seq_t    seq_next;
    logic [19:0] arm_cnt_reg;
    logic        busy_reg;
    logic [7:0]  per_cnt_reg;
    logic [6:0]  div_cnt_reg;
    logic        div_tick_reg;
    logic [7:0]  wr_addr_reg;
    logic [7:0]  wr_data_reg;
    logic [7:0]  mem [EWC_ARRAY_BYTES];

    // Timer
    logic [7:0]  tcnt;
    logic        ttog;
    logic        ttick;

    ewc_aux_timer u_timer (
        .hclk        (hclk),
        .hresetn     (hresetn),
        .enable      (tmode_reg[EWC_TMODE_EN]),
        .clk_sel     (tmode_reg[EWC_TMODE_CLK_LO +: 2]),
        .compare     (tcmp_reg),
        .counter     (tcnt),
        .toggle_q    (ttog),
        .period_tick (ttick)
    );

    // Bus decode
    wire addr_ph  = hsel && htrans[1] && hready;
    wire wr_go    = dph_reg && dwr_reg;
    wire rd_go    = dph_reg && !dwr_reg;
    wire wr_ctrl  = wr_go && (daddr_reg == EWC_OFS_CTRL);
    wire wr_tmode = wr_go && (daddr_reg == EWC_OFS_TMODE);
    wire wr_tcmp  = wr_go && (daddr_reg == EWC_OFS_TCMP);
    wire wr_aaddr = wr_go && (daddr_reg == EWC_OFS_ADDR);
    wire wr_data  = wr_go && (daddr_reg == EWC_OFS_DATA);
    wire wr_istat = wr_go && (daddr_reg == EWC_OFS_ISTAT);
    wire wr_imask = wr_go && (daddr_reg == EWC_OFS_IMASK);

    // Incoming control fields; write enable forced low without read
    wire       new_re  = hwdata[EWC_CTRL_RE];
    wire       new_we  = hwdata[EWC_CTRL_WE] && new_re;
    wire [2:0] new_sel = hwdata[EWC_CTRL_SEL_LO +: 3];
    wire       timer_run = tmode_reg[EWC_TMODE_EN];

    // Count clock period pulse of the selected source
    wire use_timer = (sel_reg == EWC_SEL_TIMER);
    wire period_ev = use_timer ? ttick :
                     (sel_reg == EWC_SEL_SYSDIV) && div_tick_reg;
    wire last_per  = (per_cnt_reg == 8'(EWC_WRITE_PERIODS - 1));
    wire wr_done   = busy_reg && period_ev && last_per;

    // Write acceptance
    wire upper     = (aaddr_reg >= 8'(EWC_AREA1_BYTES));
    wire prot_ok   = !upper || upper_area_write_protect_pin;
    wire wr_accept = wr_data && (seq_reg == EWC_WRITE) && !busy_reg &&
                     !stop_mode && prot_ok;
    wire wr_reject = wr_data && !wr_accept;
    wire readable  = re_reg && !busy_reg && !stop_mode &&
                     (seq_reg != EWC_STANDBY);

    // Access sequence next state
    always_comb begin
        seq_next = seq_reg;
        if (wr_ctrl) begin
            if (!new_re) begin
                seq_next = EWC_STANDBY;
            end else if (!re_reg) begin
                seq_next = new_we ? EWC_BLOCK : EWC_READ;
            end else if (new_we && !we_reg) begin
                seq_next = (clk_ok_reg && seq_reg == EWC_READ &&
                            new_sel == sel_reg) ?
                           EWC_ARM : EWC_BLOCK;
            end else if (!new_we && seq_reg != EWC_BLOCK) begin
                seq_next = EWC_READ;
            end
        end else begin
            case (seq_reg)
                EWC_ARM: begin
                    if (arm_cnt_reg == 20'(ARM_CYCLES - 1)) begin
                        seq_next = EWC_WRITE;
                    end
                end
                EWC_STANDBY, EWC_READ, EWC_WRITE, EWC_BLOCK: begin
                    seq_next = seq_reg;
                end
                default: begin
                    seq_next = EWC_STANDBY;
                end
            endcase
        end
    end

    // Read data selection
    logic [31:0] rd_mux;
    always_comb begin
        rd_mux = 32'h0000_0000;
        case (daddr_reg)
            EWC_OFS_CTRL: begin
                rd_mux[EWC_CTRL_PIN]          = upper_area_write_protect_pin;
                rd_mux[EWC_CTRL_SEL_LO +: 3]  = sel_reg;
                rd_mux[EWC_CTRL_ONE]          = 1'b1;
                rd_mux[EWC_CTRL_RE]           = re_reg;
                rd_mux[EWC_CTRL_BUSY]         = busy_reg;
                rd_mux[EWC_CTRL_WE]           = we_reg;
            end
            EWC_OFS_TMODE: rd_mux[7:0] = tmode_reg;
            EWC_OFS_TCMP:  rd_mux[7:0] = tcmp_reg;
            EWC_OFS_TCNT:  rd_mux[7:0] = tcnt;
            EWC_OFS_ADDR:  rd_mux[7:0] = aaddr_reg;
            EWC_OFS_DATA:  rd_mux[7:0] = readable ? mem[aaddr_reg] :
                                                     8'h00;
            EWC_OFS_ISTAT: rd_mux[EWC_IRQ_W-1:0] = istat_reg;
            EWC_OFS_IMASK: rd_mux[EWC_IRQ_W-1:0] = imask_reg;
            default:       rd_mux = 32'h0000_0000;
        endcase
    end

    // Bus handshake: one wait state per transfer
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dph_reg    <= 1'b0;
            dwr_reg    <= 1'b0;
            daddr_reg  <= 8'h00;
            hready_reg <= 1'b1;
            hrdata_reg <= 32'h0000_0000;
        end else begin
            dph_reg <= addr_ph && (hsize == EWC_HSIZE_WORD);
            if (addr_ph) begin
                dwr_reg    <= hwrite;
                daddr_reg  <= {haddr[7:2], 2'b00};
                hready_reg <= 1'b0;
            end else begin
                hready_reg <= 1'b1;
            end
            if (rd_go) begin
                hrdata_reg <= rd_mux;
            end
        end
    end

    // Control register: enables and count clock selection
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            re_reg     <= 1'b0;
            we_reg     <= 1'b0;
            sel_reg    <= EWC_SEL_RESET;
            clk_ok_reg <= 1'b0;
        end else if (wr_ctrl) begin
            re_reg  <= new_re;
            we_reg  <= new_we;
            sel_reg <= new_sel;
            if (new_sel != sel_reg) begin
                clk_ok_reg <= (new_sel == EWC_SEL_SYSDIV) ||
                              ((new_sel == EWC_SEL_TIMER) &&
                               timer_run);
            end
        end
    end

    // Timer, address and mask registers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tmode_reg <= 8'h00;
            tcmp_reg  <= 8'h00;
            aaddr_reg <= 8'h00;
            imask_reg <= '0;
        end else begin
            if (wr_tmode) tmode_reg <= hwdata[7:0] & 8'h86;
            if (wr_tcmp)  tcmp_reg  <= hwdata[7:0];
            if (wr_aaddr) aaddr_reg <= hwdata[7:0];
            if (wr_imask) imask_reg <= hwdata[EWC_IRQ_W-1:0];
        end
    end

    // Sequence state and the arm wait counter
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            seq_reg     <= EWC_STANDBY;
            arm_cnt_reg <= 20'h0_0000;
        end else begin
            seq_reg     <= seq_next;
            arm_cnt_reg <= (seq_next == EWC_ARM && seq_reg == EWC_ARM) ?
                           arm_cnt_reg + 20'h0_0001 : 20'h0_0000;
        end
    end

    // System clock division by 128 for the count clock
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            div_cnt_reg  <= 7'h00;
            div_tick_reg <= 1'b0;
        end else begin
            div_cnt_reg  <= div_cnt_reg + 7'h01;
            div_tick_reg <= (div_cnt_reg == 7'(EWC_SYSDIV_RATIO - 1));
        end
    end

    // Cell write timing over 145 count periods
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            busy_reg    <= 1'b0;
            per_cnt_reg <= 8'h00;
            wr_addr_reg <= 8'h00;
            wr_data_reg <= 8'h00;
        end else if (wr_accept) begin
            busy_reg    <= 1'b1;
            per_cnt_reg <= 8'h00;
            wr_addr_reg <= aaddr_reg;
            wr_data_reg <= hwdata[7:0];
        end else if (wr_done) begin
            busy_reg    <= 1'b0;
            per_cnt_reg <= 8'h00;
        end else if (busy_reg && period_ev) begin
            per_cnt_reg <= per_cnt_reg + 8'h01;
        end
    end

    // Array storage, committed when the timing completes
    always_ff @(posedge hclk) begin
        if (wr_done) begin
            mem[wr_addr_reg] <= wr_data_reg;
        end
    end

    // Sticky interrupt flags; a new event beats a clear
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            istat_reg <= '0;
            irq_reg   <= 1'b0;
        end else begin
            istat_reg <= (istat_reg &
                          ~(wr_istat ? hwdata[EWC_IRQ_W-1:0] : '0)) |
                         {wr_reject, wr_done};
            irq_reg   <= |(istat_reg & imask_reg);
        end
    end

    // Low power: standby without read enable, or forced by stop
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            stby_reg <= 1'b1;
        end else begin
            stby_reg <= !re_reg || stop_mode;
        end
    end

    // Outputs
    assign hreadyout       = hready_reg;
    assign hresp           = 1'b0;
    assign hrdata          = hrdata_reg;
    assign array_standby   = stby_reg;
    assign write_busy_flag = busy_reg;
    assign irq             = irq_reg;

endmodule : ewc_top

//--- bench/ewc_checker.sv
// Port checker for the write control block, bound into ewc_top.
// Assumes one clock domain and hready fed from hreadyout.
`timescale 1ns/1ps
module ewc_checker (
    input wire logic        hclk,            // System clock
    input wire logic        hresetn,         // Async reset, active low
    input wire logic        hsel,            // Slave select
    input wire logic [1:0]  htrans,          // Transfer type
    input wire logic [2:0]  hsize,           // Transfer size
    input wire logic        hready,          // Bus ready in
    input wire logic        hreadyout,       // Slave ready
    input wire logic        hresp,           // Response
    input wire logic [31:0] hrdata,          // Read data
    input wire logic        stop_mode,       // Stop state
    input wire logic        array_standby,   // Low power flag
    input wire logic        write_busy_flag  // Write in progress
);
    logic [19:0] busy_len;  // Length of the running write
    wire         take;      // Accepted address phase

    assign take = hsel && htrans[1] && hready && hsize == 3'h2;

    // Count the cycles of each write
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) busy_len <= 20'h0;
        else if (write_busy_flag) busy_len <= busy_len + 20'h1;
        else busy_len <= 20'h0;
    end

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    a_resp_okay: assert property (hresp == 1'b0)
        else $error("response not okay");
    a_wait_one: assert property (take |=> !hreadyout ##1 hreadyout)
        else $error("wait state not one cycle");
    a_ready_cause: assert property (!hreadyout |-> $past(take))
        else $error("wait state without transfer");
    a_rdata_hold: assert property ($changed(hrdata) |-> !$past(hreadyout))
        else $error("read data moved outside a read");
    a_stop_standby: assert property (stop_mode |=> array_standby)
        else $error("stop without low power");
    a_standby_exit: assert property (
        $fell(array_standby) |-> !$past(stop_mode))
        else $error("left low power during stop");
    a_busy_awake: assert property (
        write_busy_flag && !stop_mode |=> !array_standby)
        else $error("array asleep during a write");
    a_busy_min: assert property (
        $fell(write_busy_flag) |-> busy_len >= 20'h118)
        else $error("write shorter than its timing");
    a_busy_rise: assert property ($rose(write_busy_flag) |->
        !$past(hreadyout) || !$past(hreadyout, 2))
        else $error("busy rose without a transfer");
    a_busy_held: assert property (
        $rose(write_busy_flag) |-> write_busy_flag [*8])
        else $error("busy dropped at once");
endmodule : ewc_checker

bind ewc_top ewc_checker ewc_checker_inst (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans),
    .hsize(hsize), .hready(hready), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .stop_mode(stop_mode),
    .array_standby(array_standby), .write_busy_flag(write_busy_flag));

//--- bench/ewc_far_side.sv
// Model of the outside party: stop request and protect pin.
// Assumes the bench asks for levels; the model keeps them legal.
`timescale 1ns/1ps
module ewc_far_side (
    input  wire logic hclk,      // System clock
    input  wire logic busy,      // Write busy from the block
    input  wire logic pin_req,   // Wanted protect pin level
    input  wire logic stop_req,  // Wanted stop state
    output logic      pin,       // Protect pin to the block
    output logic      stop       // Stop state to the block
);
    logic pin_q  = 1'b1;  // Protect pin level held for the block
    logic stop_q = 1'b0;  // Stop level held for the block

    // Levels only move while no write runs
    always @(posedge hclk) begin
        if (!busy) begin
            pin_q  <= pin_req;
            stop_q <= stop_req;
        end
    end

    assign pin  = pin_q;
    assign stop = stop_q;
endmodule : ewc_far_side

//--- bench/test_ewc_top.sv
// Self-checking bench for the write control block.
// Assumes the far-side model and the bound port checker.
`timescale 1ns/1ps
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin \
    error_cnt++; $display("mismatch t=%0t got=%h exp=%h", \
    $time, a, e); end end
module test_ewc_top;
    import ewc_pkg::*;
    localparam int ARM = 20;  // Shortened arming wait
    logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, irq;
    logic [7:0] haddr = 0;
    logic [1:0] htrans = 0;
    logic [2:0] hsize = 0;
    logic [31:0] hwdata = 0, hrdata;
    logic hreadyout, hresp, pin, stop, standby, busy;
    logic pin_req = 1, stop_req = 0;
    wire hready = hreadyout;
    int error_cnt = 0, cmp_count = 0, n;

    always #5 hclk = ~hclk;

    ewc_top #(.ARM_CYCLES(ARM)) ewc_top_inst (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata),
        .upper_area_write_protect_pin(pin), .stop_mode(stop),
        .array_standby(standby), .write_busy_flag(busy), .irq(irq));
    ewc_far_side ewc_far_side_inst (.hclk(hclk), .busy(busy),
        .pin_req(pin_req), .stop_req(stop_req), .pin(pin),
        .stop(stop));

    task automatic give_verdict;
        $display("compares %0d errors %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : give_verdict

    task automatic timeout;
        error_cnt++;
        give_verdict();
    endtask : timeout

    // One single word transfer, waiting on hready each phase
    task automatic xfer(input logic [7:0] a, input logic w,
                        input logic [31:0] d, output logic [31:0] r);
        int k;
        @(posedge hclk);
        hsel <= 1; htrans <= 2'h2; haddr <= a; hwrite <= w;
        hsize <= EWC_HSIZE_WORD;
        k = 0;
        do begin @(posedge hclk); k++; end
        while (hreadyout !== 1'b1 && k < 50);
        if (k >= 50) timeout();
        hsel <= 0; htrans <= 2'h0; hwdata <= d;
        k = 0;
        do begin @(posedge hclk); k++; end
        while (hreadyout !== 1'b1 && k < 50);
        r = hrdata;
        if (k >= 50) timeout();
    endtask : xfer

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        xfer(a, 1'b1, d, r);
    endtask : wr

    task automatic chk_rd(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] r;
        xfer(a, 1'b0, 32'h0, r);
        `CHK(r, e)
    endtask : chk_rd

    task automatic wait_idle(output int c);
        c = 0;
        while (busy !== 1'b0 && c < 30000) begin
            @(posedge hclk);
            c++;
        end
        if (c >= 30000) timeout();
    endtask : wait_idle

    // Set the array address and start a cell write
    task automatic put(input logic [7:0] a, input logic [7:0] d);
        wr(EWC_OFS_ADDR, {24'h0, a});
        wr(EWC_OFS_DATA, {24'h0, d});
    endtask : put

    task automatic t_reset;
        chk_rd(EWC_OFS_CTRL, 32'h88);
        `CHK(standby, 1'b1)
        chk_rd(EWC_OFS_DATA, 32'h0);
        chk_rd(8'h40, 32'h0);
        wr(8'h40, 32'h1234);
        chk_rd(8'h40, 32'h0);
        `CHK(irq, 1'b0)
    endtask : t_reset

    task automatic t_bad_order;
        wr(EWC_OFS_CTRL, 32'h48);
        wr(EWC_OFS_CTRL, 32'h49);
        chk_rd(EWC_OFS_CTRL, 32'hC8);
        wr(EWC_OFS_CTRL, 32'h4D);
        repeat (ARM + 5) @(posedge hclk);
        put(8'h01, 8'h11);
        chk_rd(EWC_OFS_ISTAT, 32'h2);
        `CHK(busy, 1'b0)
        wr(EWC_OFS_ISTAT, 32'h3);
        wr(EWC_OFS_CTRL, 32'h49);
        chk_rd(EWC_OFS_CTRL, 32'hC8);
        repeat (2) @(posedge hclk);
        `CHK(standby, 1'b1)
    endtask : t_bad_order

    task automatic t_stopped_clk;
        wr(EWC_OFS_TMODE, 32'h0);
        wr(EWC_OFS_TCMP, 32'h0);
        wr(EWC_OFS_CTRL, 32'h68);
        wr(EWC_OFS_CTRL, 32'h6C);
        wr(EWC_OFS_CTRL, 32'h6D);
        wr(EWC_OFS_TMODE, 32'h80);
        repeat (ARM + 5) @(posedge hclk);
        put(8'h02, 8'h22);
        chk_rd(EWC_OFS_ISTAT, 32'h2);
        wr(EWC_OFS_ISTAT, 32'h3);
        wr(EWC_OFS_CTRL, 32'h49);
    endtask : t_stopped_clk

    task automatic t_sysdiv_write;
        wr(EWC_OFS_CTRL, 32'h4C);
        repeat (2) @(posedge hclk);
        `CHK(standby, 1'b0)
        wr(EWC_OFS_CTRL, 32'h4D);
        repeat (ARM + 5) @(posedge hclk);
        wr(EWC_OFS_IMASK, 32'h0);
        put(8'h05, 8'hA5);
        `CHK(busy, 1'b1)
        wr(EWC_OFS_DATA, 32'h5A);
        chk_rd(EWC_OFS_ISTAT, 32'h2);
        chk_rd(EWC_OFS_DATA, 32'h0);
        chk_rd(EWC_OFS_CTRL, 32'hCF);
        wait_idle(n);
        `CHK(n >= 18380 && n <= 18562, 1'b1)
        chk_rd(EWC_OFS_DATA, 32'hA5);
        chk_rd(EWC_OFS_ISTAT, 32'h3);
        `CHK(irq, 1'b0)
        wr(EWC_OFS_IMASK, 32'h1);
        repeat (2) @(posedge hclk);
        `CHK(irq, 1'b1)
        wr(EWC_OFS_ISTAT, 32'h3);
        repeat (2) @(posedge hclk);
        `CHK(irq, 1'b0)
    endtask : t_sysdiv_write

    task automatic t_protect_timer;
        pin_req <= 0;
        wr(EWC_OFS_CTRL, 32'h49);
        wr(EWC_OFS_TMODE, 32'h80);
        wr(EWC_OFS_CTRL, 32'h68);
        wr(EWC_OFS_CTRL, 32'h6C);
        wr(EWC_OFS_CTRL, 32'h6D);
        repeat (ARM + 5) @(posedge hclk);
        put(8'hC8, 8'h3C);
        chk_rd(EWC_OFS_ISTAT, 32'h2);
        wr(EWC_OFS_ISTAT, 32'h3);
        put(8'h64, 8'h77);
        wait_idle(n);
        `CHK(n >= 250 && n <= 292, 1'b1)
        chk_rd(EWC_OFS_ISTAT, 32'h1);
        wr(EWC_OFS_ISTAT, 32'h3);
        pin_req <= 1;
        put(8'hC8, 8'h3C);
        wait_idle(n);
        chk_rd(EWC_OFS_DATA, 32'h3C);
        wr(EWC_OFS_ADDR, 32'h64);
        chk_rd(EWC_OFS_DATA, 32'h77);
    endtask : t_protect_timer

    task automatic t_stop;
        wr(EWC_OFS_CTRL, 32'h6C);
        stop_req <= 1;
        repeat (3) @(posedge hclk);
        `CHK(standby, 1'b1)
        chk_rd(EWC_OFS_CTRL, 32'hEC);
        chk_rd(EWC_OFS_DATA, 32'h0);
        stop_req <= 0;
        repeat (3) @(posedge hclk);
        `CHK(standby, 1'b0)
    endtask : t_stop

    initial begin
        repeat (8) @(posedge hclk);
        hresetn <= 1;
        t_reset();
        t_bad_order();
        t_stopped_clk();
        t_sysdiv_write();
        t_protect_timer();
        t_stop();
        give_verdict();
    end
endmodule : test_ewc_top
